// >>> core/bus_port_consts.vh
// Constants for the bus remote/local interface block
`ifndef BUS_PORT_CONSTS_VH
`define BUS_PORT_CONSTS_VH

// =====================================================================
// Command codes on cmd_code
`define CMD_NONE 4'h0
`define CMD_IFC 4'h1
`define CMD_LLO 4'h2
`define CMD_GTL 4'h3
`define CMD_DCL 4'h4
`define CMD_SDC 4'h5
`define CMD_GET 4'h6
`define CMD_SPE 4'h7
`define CMD_SPD 4'h8
`define CMD_UNT 4'h9
`define CMD_UNL 4'ha
`define CMD_MTA 4'hb
`define CMD_MLA 4'hc
`define CMD_OTA 4'hd

// =====================================================================
// Status byte and condition register bit positions and sizes
`define STB_MAV 4
`define STB_RQS 6
`define OPER_MEAS 4
`define COND_W 16
`define NUM_SETS 4

// =====================================================================
// Trigger layers and clear timing
`define LAYER_ARM 0
`define LAYER_SCAN 1
`define LAYER_MEAS 2
`define IFC_MIN_NS 100000
`define CLK_NS 10
`define IFC_CYC ((`IFC_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define IFC_CNT_W 14

`endif

// >>> core/ifc_qualifier.v
// Interface-clear line qualifier: pulses once after a long enough hold
`timescale 1ns/1ns
`include "bus_port_consts.vh"

module ifc_qualifier (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire ifc_line,
   output reg ifc_pulse
);

   reg [`IFC_CNT_W-1:0] cnt_q;

   // =====================================================================
   // Hold counter
   // Shorter glitches are ignored so line noise cannot drop addressing
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= {`IFC_CNT_W{1'b0}};
         ifc_pulse <= 1'b0;
      end else if (ce) begin
         ifc_pulse <= 1'b0;
         if (!ifc_line) begin
            cnt_q <= {`IFC_CNT_W{1'b0}};
         end else if (cnt_q != `IFC_CYC) begin
            cnt_q <= cnt_q + 1'b1;
            // R3: minimum hold reached
            if (cnt_q == `IFC_CYC - 1) begin
               ifc_pulse <= 1'b1;
            end
         end
      end
   end

endmodule // ifc_qualifier

// >>> core/status_sets.v
// Condition registers of the status sets and their summary bits
`timescale 1ns/1ns
`include "bus_port_consts.vh"

module status_sets (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire [`NUM_SETS*`COND_W-1:0] cond_in,
   input wire meas_busy,
   input wire [`NUM_SETS*`COND_W-1:0] cond_mask,
   output reg [`NUM_SETS*`COND_W-1:0] cond_q,
   output reg [`NUM_SETS-1:0] summary_q
);

   // =====================================================================
   // One condition register per set
   genvar g;
   generate
      for (g = 0; g < `NUM_SETS; g = g + 1) begin : set_g
         wire [`COND_W-1:0] live;
         // R17: measuring bit tracks busy
         assign live = (g == 0) ?
            ((cond_in[g*`COND_W +: `COND_W] & ~(16'h0001 << `OPER_MEAS))
             | ({{(`COND_W-1){1'b0}}, meas_busy} << `OPER_MEAS))
            : cond_in[g*`COND_W +: `COND_W];
         // R18: each set feeds a summary
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               cond_q[g*`COND_W +: `COND_W] <= {`COND_W{1'b0}};
               summary_q[g] <= 1'b0;
            end else if (ce) begin
               cond_q[g*`COND_W +: `COND_W] <= live;
               summary_q[g] <= |(live & cond_mask[g*`COND_W +: `COND_W]);
            end
         end
      end
   endgenerate

endmodule // status_sets

// >>> core/bus_remote_local.v
// Instrument-side remote/local, addressing, clear and poll logic
// Contract
// R1: Interface clear: local, talker and listener idle
// R2: Interface clear keeps settings and events
// R3: Controller holds clear at least 100 us
// R4: Lockout ignores all keys but power
// R5: Go-to-local leaves remote, ends lockout
// R6: Device clear empties buffers, cancels commands
// R7: Device clear keeps settings and data
// R8: Universal clear acts even when unaddressed
// R9: Selected clear only when addressed listener
// R10: Bus trigger fires layers sourced from bus
// R11: Serial poll returns status byte anytime
// R12: Remote needs listen address with enable
// R13: Talk address sets talker; idle conditions
// R14: Listen address sets listener; idle conditions
// R15: Service request lit until poll or cleared
// R16: Local key cancels remote unless locked
// R17: Condition registers real time, measuring bit
// R18: Four status sets feed status byte
// R19: Message available follows output queue
// R20: Unsourced bus trigger silently ignored
`timescale 1ns/1ns
`include "bus_port_consts.vh"

module bus_remote_local (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire ren_line,
   input wire ifc_line,
   input wire cmd_valid,
   input wire [3:0] cmd_code,
   input wire key_local,
   input wire [7:0] key_other,
   input wire [2:0] trig_src_bus,
   input wire outq_not_empty,
   input wire errq_not_empty,
   input wire [`NUM_SETS*`COND_W-1:0] cond_in,
   input wire [`NUM_SETS*`COND_W-1:0] cond_mask,
   input wire meas_busy,
   input wire [7:0] sre_mask,
   input wire stb_read,
   output reg remote_indicator,
   output reg talk_indicator,
   output reg listener_indicator,
   output reg lockout_q,
   output reg srq_indicator,
   output reg [7:0] key_out,
   output reg clear_pulse,
   output reg [2:0] trig_pulse,
   output reg spoll_active,
   output reg [7:0] spoll_byte,
   output reg [7:0] stb_q,
   output reg display_restore,
   output wire [`NUM_SETS*`COND_W-1:0] cond_regs
);

   wire ifc_pulse;
   wire [`NUM_SETS-1:0] summary;
   wire cmd;
   wire [7:0] stb_live;
   wire rqs_d;
   reg rqs_q;
   reg rqs_armed_q;

   assign cmd = ce && cmd_valid;

   // =====================================================================
   // Submodules
   ifc_qualifier u_ifc (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .ifc_line(ifc_line),
      .ifc_pulse(ifc_pulse)
   );

   status_sets u_sets (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .cond_in(cond_in),
      .meas_busy(meas_busy),
      .cond_mask(cond_mask),
      .cond_q(cond_regs),
      .summary_q(summary)
   );

   // =====================================================================
   // Status byte assembly
   // R18: summaries into status byte
   // R19: message available from queue
   assign stb_live = {summary[0], 1'b0, 1'b0, outq_not_empty,
                      summary[3], errq_not_empty, summary[2], summary[1]};
   // Any enabled status byte bit, bit 6 excluded
   assign rqs_d = |(stb_live & sre_mask & 8'hbf);

   // =====================================================================
   // Addressing states
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         talk_indicator <= 1'b0;
         listener_indicator <= 1'b0;
      end else if (ce) begin
         // R1: clear wins over addressing
         if (ifc_pulse) begin
            talk_indicator <= 1'b0;
            listener_indicator <= 1'b0;
         end else if (cmd) begin
            case (cmd_code)
               // R13: own talk address
               `CMD_MTA: begin
                  talk_indicator <= 1'b1;
                  // R14: addressed to talk
                  listener_indicator <= 1'b0;
               end
               // R14: own listen address
               `CMD_MLA: begin
                  listener_indicator <= 1'b1;
                  // R13: addressed to listen
                  talk_indicator <= 1'b0;
               end
               `CMD_UNT: talk_indicator <= 1'b0;
               `CMD_UNL: listener_indicator <= 1'b0;
               // Another device talks, so we stop
               `CMD_OTA: talk_indicator <= 1'b0;
               default: begin
                  talk_indicator <= talk_indicator;
               end
            endcase
         end
      end
   end

   // =====================================================================
   // Remote and lockout
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         remote_indicator <= 1'b0;
         lockout_q <= 1'b0;
         display_restore <= 1'b0;
      end else if (ce) begin
         display_restore <= 1'b0;
         // R1: clear returns to local
         if (ifc_pulse) begin
            remote_indicator <= 1'b0;
         // R5: go to local
         end else if (cmd && cmd_code == `CMD_GTL) begin
            remote_indicator <= 1'b0;
            lockout_q <= 1'b0;
            display_restore <= 1'b1;
         // R12: listen address with enable
         end else if (cmd && cmd_code == `CMD_MLA && ren_line) begin
            remote_indicator <= 1'b1;
         // R16: local key unless locked
         end else if (key_local && !lockout_q && remote_indicator) begin
            remote_indicator <= 1'b0;
            display_restore <= 1'b1;
         end
         // Lockout persists until go-to-local; dropping enable also frees
         if (cmd && cmd_code == `CMD_LLO) begin
            lockout_q <= 1'b1;
         end
         if (!ren_line) begin
            remote_indicator <= 1'b0;
            lockout_q <= 1'b0;
         end
      end
   end

   // =====================================================================
   // Front-panel key gating
   // R4: lockout blocks keys; R12: remote blocks all but local
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         key_out <= 8'h00;
      end else if (ce) begin
         if (lockout_q || remote_indicator) begin
            key_out <= 8'h00;
         end else begin
            key_out <= key_other;
         end
      end
   end

   // =====================================================================
   // Device clear and trigger
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         clear_pulse <= 1'b0;
         trig_pulse <= 3'h0;
      end else if (ce) begin
         clear_pulse <= 1'b0;
         trig_pulse <= 3'h0;
         if (cmd) begin
            case (cmd_code)
               // R8: universal clear, any address
               // R6: buffers emptied by clear_pulse
               // R7: settings untouched here
               `CMD_DCL: clear_pulse <= 1'b1;
               // R9: only when listening
               `CMD_SDC: clear_pulse <= listener_indicator;
               // R10: per layer source
               // R20: unsourced trigger dropped
               `CMD_GET: begin
                  if (listener_indicator) begin
                     trig_pulse <= trig_src_bus;
                  end
               end
               default: clear_pulse <= 1'b0;
            endcase
         end
      end
   end
   // R2: interface clear touches none of the above

   // =====================================================================
   // Serial poll and service request
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         spoll_active <= 1'b0;
         spoll_byte <= 8'h00;
         stb_q <= 8'h00;
         rqs_q <= 1'b0;
         rqs_armed_q <= 1'b0;
         srq_indicator <= 1'b0;
      end else if (ce) begin
         stb_q <= {stb_live[7], rqs_d, stb_live[5:0]};
         rqs_armed_q <= rqs_d;
         // R15: new request sets, poll or loss clears
         if (rqs_d && !rqs_armed_q) begin
            rqs_q <= 1'b1;
         end else if (!rqs_d || (stb_read && spoll_active)) begin
            rqs_q <= 1'b0;
         end
         srq_indicator <= (rqs_d && !rqs_armed_q) ||
                          (rqs_q && rqs_d && !(stb_read && spoll_active));
         // R11: poll mode by enable/disable
         if (ifc_pulse || (cmd && cmd_code == `CMD_SPD)) begin
            spoll_active <= 1'b0;
         end else if (cmd && cmd_code == `CMD_SPE) begin
            spoll_active <= 1'b1;
         end
         spoll_byte <= {stb_live[7], rqs_q, stb_live[5:0]};
      end
   end

endmodule // bus_remote_local

// >>> bench/bus_port_properties.sv
// Timing checks on the remote/local bus port
`timescale 1ns/1ns
`include "bus_port_consts.vh"
module bus_port_properties (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire ren_line,
   input wire ifc_line,
   input wire cmd_valid,
   input wire [3:0] cmd_code,
   input wire key_local,
   input wire [2:0] trig_src_bus,
   input wire outq_not_empty,
   input wire meas_busy,
   input wire remote_indicator,
   input wire talk_indicator,
   input wire listener_indicator,
   input wire lockout_q,
   input wire clear_pulse,
   input wire [2:0] trig_pulse,
   input wire [7:0] stb_q,
   input wire [`NUM_SETS*`COND_W-1:0] cond_regs,
   input wire [7:0] key_other,
   input wire [7:0] key_out,
   input wire stb_read,
   input wire srq_indicator,
   input wire spoll_active,
   input wire [7:0] spoll_byte,
   input wire display_restore,
   input wire [`NUM_SETS*`COND_W-1:0] cond_in,
   input wire [`NUM_SETS*`COND_W-1:0] cond_mask
);
   localparam int IFC_N = `IFC_CYC;
   logic [13:0] ifc_cnt_q;
   wire [3:0] op = (ce && cmd_valid) ? cmd_code : 4'h0;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // =====================================================
   // Helper: clear-line hold count, saturates past the qualify point
   always @(posedge clk or posedge rst) begin
      if (rst) ifc_cnt_q <= 14'h0000;
      else if (!ifc_line) ifc_cnt_q <= 14'h0000;
      else if (ce && ifc_cnt_q < IFC_N + 2) ifc_cnt_q <= ifc_cnt_q + 14'h0001;
   end
   // =====================================================
   // Assertions
   // clear ends addressing
   a_ifc_idle: assert property (ifc_cnt_q == IFC_N + 2
      |-> !talk_indicator && !listener_indicator && !remote_indicator) else $error("clear idle");
   a_lock_hold: assert property (ce && lockout_q && key_local && ren_line && !cmd_valid
      |=> lockout_q && remote_indicator == $past(remote_indicator)) else $error("lockout key");
   a_gtl_local: assert property (op == `CMD_GTL
      |=> !remote_indicator && !lockout_q) else $error("go to local");
   a_dcl_clear: assert property (op == `CMD_DCL |=> clear_pulse) else $error("dcl");
   a_sdc_gate: assert property (op == `CMD_SDC
      |=> clear_pulse == $past(listener_indicator)) else $error("sdc gate");
   a_get_trig: assert property (op == `CMD_GET
      |=> trig_pulse == ($past(listener_indicator) ? $past(trig_src_bus) : 3'h0))
      else $error("get trigger");
   a_mla_listen: assert property (op == `CMD_MLA |=> listener_indicator &&
      !talk_indicator && remote_indicator == $past(ren_line)) else $error("listen addr");
   a_mta_talk: assert property (op == `CMD_MTA
      |=> talk_indicator && !listener_indicator) else $error("talk addr");
   a_meas_bit: assert property (ce
      |=> cond_regs[`OPER_MEAS] == $past(meas_busy)) else $error("meas bit");
   a_mav_bit: assert property (ce
      |=> stb_q[`STB_MAV] == $past(outq_not_empty)) else $error("mav bit");
   a_gtl_restore: assert property (op == `CMD_GTL |=> display_restore) else $error("gtl display");
   a_key_local: assert property (ce && key_local && remote_indicator && !lockout_q &&
      ren_line && !cmd_valid |=> !remote_indicator && display_restore) else $error("local key");
   a_key_gate: assert property (ce |=> key_out ==
      (($past(lockout_q) || $past(remote_indicator)) ? 8'h00 : $past(key_other)))
      else $error("key gate");
   a_poll_on: assert property (op == `CMD_SPE |=> spoll_active) else $error("poll on");
   a_poll_off: assert property (op == `CMD_SPD |=> !spoll_active) else $error("poll off");
   // poll byte is the status byte with bit 6 from the prior service request
   a_poll_byte: assert property (ce |=> spoll_byte ==
      {stb_q[7], $past(srq_indicator), stb_q[5:0]}) else $error("poll byte");
   // request only while its cause stands
   a_srq_cause: assert property (srq_indicator |-> stb_q[`STB_RQS]) else $error("srq cause");
   a_srq_poll: assert property (ce && spoll_active && stb_read && srq_indicator
      |=> !srq_indicator) else $error("srq poll");
   a_cond_track: assert property (ce |=> {cond_regs[63:5], cond_regs[3:0]} ==
      {$past(cond_in[63:5]), $past(cond_in[3:0])}) else $error("cond track");
   a_set_summary: assert property (ce ##1 ce |=> stb_q[0] ==
      |($past(cond_in[31:16], 2) & $past(cond_mask[31:16], 2))) else $error("set summary");
   // Main scenarios reached
   c_poll: cover property (spoll_active && stb_read && srq_indicator);
   c_sdc: cover property (op == `CMD_SDC && listener_indicator);
   c_ifc: cover property (ifc_cnt_q == IFC_N + 2);
   c_lock: cover property (lockout_q && key_local);
endmodule // bus_port_properties

// >>> bench/bus_ctl_model.sv
// Bus controller model: remote enable, clear line and commands
`timescale 1ns/1ns
module bus_ctl_model (
   input wire clk,
   output logic ren_line,
   output logic ifc_line,
   output logic cmd_valid,
   output logic [3:0] cmd_code
);
   initial begin
      ren_line = 1'b0;
      ifc_line = 1'b0;
      cmd_valid = 1'b0;
      cmd_code = 4'h0;
   end
   // One command; code 0 sends nothing, idle code is never the last one
   task automatic send(input logic r, input logic [3:0] c);
      @(posedge clk);
      ren_line <= r;
      cmd_valid <= (c != 4'h0);
      cmd_code <= c;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_code <= ~c;
   endtask
   task automatic ifc_hold(input int n);
      @(posedge clk);
      ifc_line <= 1'b1;
      repeat (n) @(posedge clk);
      ifc_line <= 1'b0;
   endtask
endmodule // bus_ctl_model

// >>> bench/test_bus_remote_local.sv
// Self-checking bench of the bus remote/local block
`timescale 1ns/1ns
`include "bus_port_consts.vh"
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin mismatches++; \
   $display("FAIL %0t %s", $time, m); end end
module test_bus_remote_local;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic key_local = 1'b0;
   logic stb_read = 1'b0;
   logic outq_not_empty = 1'b0, errq_not_empty = 1'b0, meas_busy = 1'b0;
   logic [7:0] key_other = 8'h00, sre_mask = 8'h00;
   logic [2:0] trig_src_bus = 3'h0;
   logic [`NUM_SETS*`COND_W-1:0] cond_in = '0, cond_mask = '0;
   wire ren_line, ifc_line, cmd_valid, remote_indicator, talk_indicator;
   wire listener_indicator, lockout_q, srq_indicator, clear_pulse, spoll_active;
   wire display_restore;
   wire [3:0] cmd_code;
   wire [7:0] key_out, spoll_byte, stb_q;
   wire [2:0] trig_pulse;
   wire [`NUM_SETS*`COND_W-1:0] cond_regs;
   int mismatches = 0;
   int compares = 0;
   integer seed = 32'hc1aa303b;
   logic [31:0] r;
   logic [3:0] exq[$];
   logic [3:0] note;
   // Steps {ren, local key, command, remote/talk/listen/lockout}
   // Poll is enabled from step 20 through step 23 so reads meet a pending request
   localparam logic [9:0] T [25] = '{10'h0c2, 10'h2ca, 10'h2bc, 10'h2ca, 10'h22b,
      10'h30b, 10'h232, 10'h2ca, 10'h002, 10'h2ca, 10'h302, 10'h242, 10'h252,
      10'h262, 10'h2a0, 10'h250, 10'h260, 10'h2b4, 10'h290, 10'h2ca, 10'h27a,
      10'h2bc, 10'h2d8, 10'h248, 10'h288};
   always #5 clk = ~clk;
   bus_ctl_model u_ctl (.*);
   bus_remote_local u_dut (.*);
   // =====================================================
   // Random status inputs and other keys; local key and commands are driven by the steps
   always @(posedge clk) begin
      r = $random(seed);
      key_other <= r[7:0];
      trig_src_bus <= r[10:8];
      outq_not_empty <= r[11];
      errq_not_empty <= r[12];
      meas_busy <= r[13];
      stb_read <= r[22];
      sre_mask <= r[21:14];
      cond_in <= {$random(seed), $random(seed)};
      cond_mask <= {$random(seed), $random(seed)};
   end
   // Oldest note against settled indicators, off the clock edge
   always @(negedge clk) begin
      if (exq.size() > 0) begin
         note = exq.pop_front();
         `CHK({remote_indicator, talk_indicator, listener_indicator, lockout_q}, note, "state")
      end
   end
   task automatic summarize();
      if (mismatches == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // =====================================================
   // Main sequence: table steps, then a qualified clear
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 25; i++) begin
         key_local <= T[i][8];
         u_ctl.send(T[i][9], T[i][7:4]);
         key_local <= 1'b0;
         @(posedge clk);
         exq.push_back(T[i][3:0]);
      end
      u_ctl.ifc_hold(`IFC_CYC + 4);
      repeat (3) @(posedge clk);
      exq.push_back(4'h0);
      repeat (2) @(posedge clk);
      summarize();
   end
   // Watchdog: the run needs about 10100 cycles
   initial begin
      #500000;
      mismatches++;
      summarize();
   end
endmodule // test_bus_remote_local
bind bus_remote_local bus_port_properties u_props (.*);
